// *** core/rwio_pkg.sv ***
// Shared constants and carrier types of the ROM and I/O port bus slave
package rwio_pkg;

    // Widths of the bus, ports and ROM address
    localparam int unsigned BUS_W      = 8;
    localparam int unsigned PORT_W     = 8;
    localparam int unsigned UPPER_W    = 3;
    localparam int unsigned ROM_AW     = 11;
    localparam int unsigned ROM_DEPTH  = 2048;

    // Positions of the captured low address bits used by the I/O section
    localparam int unsigned PORT_SEL_BIT = 0;   // 0 first port, 1 second port
    localparam int unsigned DIR_SEL_BIT  = 1;   // 1 targets the direction register

    // Reset values
    localparam logic [PORT_W-1:0]  DIR_RST   = 8'h00;   // All lines input
    localparam logic [PORT_W-1:0]  LATCH_RST = 8'h00;
    localparam logic [BUS_W-1:0]   BUS_RST   = 8'h00;
    localparam logic [BUS_W-1:0]   ADDR_RST  = 8'h00;
    localparam logic [UPPER_W-1:0] UPPER_RST = 3'h0;

    // Mask ROM fill pattern seed; arbitrary contents
    localparam logic [BUS_W-1:0] ROM_SEED = 8'h5a;

    // One pin group as driven by the block
    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
    } rwio_pins_s;

    // Fixed mask contents, a function of the address
    function automatic logic [BUS_W-1:0] romByte(input logic [ROM_AW-1:0] addr);
        romByte = addr[7:0] ^ {addr[10:8], 5'h00} ^ ROM_SEED;
    endfunction

    // Value seen on a port read: pins for inputs, latch for outputs
    function automatic logic [PORT_W-1:0] portView(input logic [PORT_W-1:0] pins,
                                                   input logic [PORT_W-1:0] latch,
                                                   input logic [PORT_W-1:0] dir);
        portView = (pins & ~dir) | (latch & dir);
    endfunction

endpackage

// *** core/rwio_rom.sv ***
// Mask ROM array of 2048 bytes with combinational read
`timescale 1ns/1ps
module rwio_rom
    import rwio_pkg::*;
(
    input  wire logic [ROM_AW-1:0] addr,
    output logic      [BUS_W-1:0]  data
);

    logic [BUS_W-1:0] romArr [ROM_DEPTH];

    // Fixed contents built from the fill function
    for (genvar i = 0; i < ROM_DEPTH; i++) begin : g_fill
        assign romArr[i] = romByte(ROM_AW'(i));
    end

    // Byte at the captured 11-bit address
    assign data = romArr[addr];

endmodule // rwio_rom

// *** core/rwio_slave.sv ***
// Bus slave of a 2048x8 mask ROM with two 8-bit general purpose I/O ports
`timescale 1ns/1ps
module rwio_slave
    import rwio_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               portReset,
    input  wire logic               latchStrobe,
    input  wire logic [BUS_W-1:0]   muxedBusLinesIn,
    output logic      [BUS_W-1:0]   muxedBusLinesOut,
    output logic                    muxedBusLinesOe,
    input  wire logic [UPPER_W-1:0] upperRomAddress,
    input  wire logic               ioSelect,
    input  wire logic               chipSelectLowN,
    input  wire logic               chipSelectHigh,
    input  wire logic               readStrobeN,
    input  wire logic               portReadStrobeN,
    input  wire logic               portWriteStrobeN,
    input  wire logic               busClock,
    output logic                    waitOut,
    output logic                    waitOe,
    input  wire logic [PORT_W-1:0]  firstPortPinsIn,
    output rwio_pins_s              firstPortPins,
    input  wire logic [PORT_W-1:0]  secondPortPinsIn,
    output rwio_pins_s              secondPortPins
);

    // Whole state of the slave
    // Captured address phase, port registers and the registered bus and
    // wait drives sit in one register, so every pin changes only on an
    // edge and no decode glitch ever reaches the bus
    typedef struct packed {
        logic [BUS_W-1:0]   capAddr;
        logic [UPPER_W-1:0] capUpper;
        logic               capIoSel;
        logic               capCsLowN;
        logic               capCsHigh;
        logic               busClockPrev;
        logic [PORT_W-1:0]  firstLatch;
        logic [PORT_W-1:0]  secondLatch;
        logic [PORT_W-1:0]  firstDir;
        logic [PORT_W-1:0]  secondDir;
        logic [BUS_W-1:0]   busOut;
        logic               busOe;
        logic               waitDrive;
    } rwio_state_s;

    localparam rwio_state_s STATE_RST = '{
        capAddr:      ADDR_RST,
        capUpper:     UPPER_RST,
        capIoSel:     1'b0,
        capCsLowN:    1'b1,
        capCsHigh:    1'b0,
        busClockPrev: 1'b0,
        firstLatch:   LATCH_RST,
        secondLatch:  LATCH_RST,
        firstDir:     DIR_RST,
        secondDir:    DIR_RST,
        busOut:       BUS_RST,
        busOe:        1'b0,
        waitDrive:    1'b0
    };

    rwio_state_s      state_ff;
    rwio_state_s      nxt_state;
    logic [BUS_W-1:0] romData;
    logic             accepted;
    logic             memRead;
    logic             portRead;
    logic             anyRead;
    logic             pickSecond;
    logic             writeStrobe;
    logic [PORT_W-1:0] firstView;
    logic [PORT_W-1:0] secondView;
    logic             liveEnables;
    logic             busClockRise;
    logic             wrFirstLatch;
    logic             wrSecondLatch;
    logic             wrFirstDir;
    logic             wrSecondDir;

    // Both chip enables in their active state; used on the captured pair
    // to accept an access and on the live pair to start the wait
    function automatic logic enablesOn(input logic csLowN, input logic csHigh);
        enablesOn = !csLowN && csHigh;
    endfunction

    // ROM addressed by the 11 captured bits
    // Upper bits only reach the ROM; the port decode never looks at them
    rwio_rom u_rom (
        .addr (ROM_AW'({state_ff.capUpper, state_ff.capAddr})),
        .data (romData)
    );

    // Decode of the current access from captured values and live strobes
    // Strobes act as levels: a strobe held low repeats its effect each cycle
    always_comb begin
        accepted     = enablesOn(state_ff.capCsLowN, state_ff.capCsHigh);
        liveEnables  = enablesOn(chipSelectLowN, chipSelectHigh);
        busClockRise = busClock && !state_ff.busClockPrev;
        memRead     = !readStrobeN;
        portRead    = !portReadStrobeN || (state_ff.capIoSel && memRead);
        anyRead     = memRead || !portReadStrobeN;
        pickSecond  = state_ff.capAddr[PORT_SEL_BIT];
        writeStrobe = accepted && !portWriteStrobeN;
        firstView   = portView(firstPortPinsIn, state_ff.firstLatch, state_ff.firstDir);
        secondView  = portView(secondPortPinsIn, state_ff.secondLatch, state_ff.secondDir);
    end

    // Write targets: bit 1 picks latch or direction register, bit 0 the port
    // Direction registers are write only; a read with bit 1 set shows the port
    always_comb begin
        wrFirstLatch  = writeStrobe && !state_ff.capAddr[DIR_SEL_BIT] && !pickSecond;
        wrSecondLatch = writeStrobe && !state_ff.capAddr[DIR_SEL_BIT] && pickSecond;
        wrFirstDir    = writeStrobe && state_ff.capAddr[DIR_SEL_BIT] && !pickSecond;
        wrSecondDir   = writeStrobe && state_ff.capAddr[DIR_SEL_BIT] && pickSecond;
    end

    // Next state
    always_comb begin
        nxt_state = state_ff;
        nxt_state.busClockPrev = busClock;

        // Transparent capture while the latch strobe is high, held after its fall
        // Enables are judged as captured, so later changes cannot cut an access
        if (latchStrobe) begin
            nxt_state.capAddr   = muxedBusLinesIn;
            nxt_state.capUpper  = upperRomAddress;
            nxt_state.capIoSel  = ioSelect;
            nxt_state.capCsLowN = chipSelectLowN;
            nxt_state.capCsHigh = chipSelectHigh;
        end

        // Bus driver: only for an accepted access with a read strobe low
        // Read data is registered, so the bus turns on one cycle after the strobe
        nxt_state.busOe = accepted && anyRead;
        if (portRead) begin
            // Port read; upper ROM bits play no part
            nxt_state.busOut = pickSecond ? secondView : firstView;
        end else begin
            nxt_state.busOut = romData;
        end

        // Port write, steered by captured bits 1 and 0; the I/O select is ignored
        // Writing a latch while its line is an input lets software preload it
        if (wrFirstLatch) begin
            nxt_state.firstLatch = muxedBusLinesIn;
        end
        if (wrSecondLatch) begin
            nxt_state.secondLatch = muxedBusLinesIn;
        end
        if (wrFirstDir) begin
            nxt_state.firstDir = muxedBusLinesIn;
        end
        if (wrSecondDir) begin
            nxt_state.secondDir = muxedBusLinesIn;
        end

        // Wait: low while enables are active and latch strobe high,
        // released on the next rising edge of the bus clock
        // Set wins over release while the latch strobe is still high
        if (latchStrobe && liveEnables) begin
            nxt_state.waitDrive = 1'b1;
        end else if (busClockRise) begin
            nxt_state.waitDrive = 1'b0;
        end else if (!latchStrobe && !accepted) begin
            nxt_state.waitDrive = 1'b0;
        end

        // Port reset input returns every line to input mode
        // Placed after the writes so it beats a direction write in the same cycle
        // Output latches keep their value through a port reset
        if (portReset) begin
            nxt_state.firstDir  = DIR_RST;
            nxt_state.secondDir = DIR_RST;
        end
    end

    // State register
    // Asynchronous clear to the reset image; everything else moves every edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= STATE_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from the state register
    // The wait pin only ever pulls low; its enable carries the state
    always_comb begin
        muxedBusLinesOut   = state_ff.busOut;
        muxedBusLinesOe    = state_ff.busOe;
        waitOut            = 1'b0;                            // Only ever driven low
        waitOe             = state_ff.waitDrive;
        firstPortPins.out  = state_ff.firstLatch;
        firstPortPins.oe   = state_ff.firstDir;
        secondPortPins.out = state_ff.secondLatch;
        secondPortPins.oe  = state_ff.secondDir;
    end

endmodule // rwio_slave

// *** dv/rwio_pin_model.sv ***
// Port pin model: external drivers meeting the block's outputs
`timescale 1ns/1ps
module rwio_pin_model
    import rwio_pkg::*;
(
    input  rwio_pins_s             drv,
    input  wire logic [PORT_W-1:0] ext,
    output logic      [PORT_W-1:0] level
);
    // Driven lines show the latch, others the outside level
    assign level = (drv.out & drv.oe) | (ext & ~drv.oe);
endmodule // rwio_pin_model

// *** dv/rwio_chk.sv ***
// Assertion checker of the ROM and I/O port bus slave
`timescale 1ns/1ps
module rwio_chk
    import rwio_pkg::*;
(
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic               portReset,
    input wire logic               latchStrobe,
    input wire logic [BUS_W-1:0]   muxedBusLinesIn,
    input wire logic [BUS_W-1:0]   muxedBusLinesOut,
    input wire logic               muxedBusLinesOe,
    input wire logic [UPPER_W-1:0] upperRomAddress,
    input wire logic               ioSelect,
    input wire logic               chipSelectLowN,
    input wire logic               chipSelectHigh,
    input wire logic               readStrobeN,
    input wire logic               portReadStrobeN,
    input wire logic               portWriteStrobeN,
    input wire logic               busClock,
    input wire logic               waitOe,
    input wire logic [PORT_W-1:0]  firstPortPinsIn,
    input wire logic [PORT_W-1:0]  secondPortPinsIn,
    input rwio_pins_s              firstPortPins,
    input rwio_pins_s              secondPortPins
);
    logic       capOk;
    logic [7:0] capA;
    logic [2:0] capU;
    logic       capIo;
    wire        act = capOk && !latchStrobe;
    wire        portRd = act && (!portReadStrobeN || (capIo && !readStrobeN));
    // Expected port views: pin levels on inputs, latch on outputs
    wire [7:0]  viewA = (firstPortPinsIn & ~firstPortPins.oe)
                      | (firstPortPins.out & firstPortPins.oe);
    wire [7:0]  viewB = (secondPortPinsIn & ~secondPortPins.oe)
                      | (secondPortPins.out & secondPortPins.oe);
    // Shadow copy of the captured address phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            capOk <= 1'b0;
        end else if (latchStrobe) begin
            capOk <= !chipSelectLowN && chipSelectHigh;
            capA <= muxedBusLinesIn;
            capU <= upperRomAddress;
            capIo <= ioSelect;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Bus, wait and port checks
    a_bus_float: assert property (readStrobeN && portReadStrobeN |=> !muxedBusLinesOe)
        else $error("bus driven without a read");
    a_idle_quiet: assert property (!capOk && !latchStrobe |=> !muxedBusLinesOe && !waitOe)
        else $error("unselected device active");
    a_read_drive: assert property (act && !(readStrobeN && portReadStrobeN) |=> muxedBusLinesOe)
        else $error("read not driven");
    a_rom_data: assert property (act && !readStrobeN && portReadStrobeN && !capIo
        |=> muxedBusLinesOut == (capA ^ {capU, 5'h00} ^ ROM_SEED)) else $error("bad ROM byte");
    a_first_write: assert property (act && !portWriteStrobeN && capA[1:0] == 2'h0
        |=> firstPortPins.out == $past(muxedBusLinesIn)) else $error("first port not written");
    a_second_write: assert property (act && !portWriteStrobeN && capA[1:0] == 2'h1
        |=> secondPortPins.out == $past(muxedBusLinesIn)) else $error("second port not written");
    a_port_reset: assert property (portReset |=> (firstPortPins.oe | secondPortPins.oe) == 8'h00)
        else $error("reset left an output");
    a_wait_set: assert property (latchStrobe && !chipSelectLowN && chipSelectHigh |=> waitOe)
        else $error("wait not asserted");
    a_wait_free: assert property (!latchStrobe && busClock && !$past(busClock) |=> !waitOe)
        else $error("wait not released");
    a_first_read: assert property (portRd && !capA[0]
        |=> muxedBusLinesOut == $past(viewA)) else $error("bad first port read");
    a_second_read: assert property (portRd && capA[0]
        |=> muxedBusLinesOut == $past(viewB)) else $error("bad second port read");
    c_read: cover property (act && !readStrobeN);
    c_write: cover property (act && !portWriteStrobeN);
    c_wait: cover property (waitOe);
endmodule // rwio_chk
bind rwio_slave rwio_chk u_chk (
    .clk              (clk),
    .rstn             (rstn),
    .portReset        (portReset),
    .latchStrobe      (latchStrobe),
    .muxedBusLinesIn  (muxedBusLinesIn),
    .muxedBusLinesOut (muxedBusLinesOut),
    .muxedBusLinesOe  (muxedBusLinesOe),
    .upperRomAddress  (upperRomAddress),
    .ioSelect         (ioSelect),
    .chipSelectLowN   (chipSelectLowN),
    .chipSelectHigh   (chipSelectHigh),
    .readStrobeN      (readStrobeN),
    .portReadStrobeN  (portReadStrobeN),
    .portWriteStrobeN (portWriteStrobeN),
    .busClock         (busClock),
    .waitOe           (waitOe),
    .firstPortPinsIn  (firstPortPinsIn),
    .secondPortPinsIn (secondPortPinsIn),
    .firstPortPins    (firstPortPins),
    .secondPortPins   (secondPortPins)
);

// *** dv/tb_top.sv ***
// Testbench of the ROM and I/O port bus slave
`timescale 1ns/1ps
module tb_top;
    import rwio_pkg::*;
    logic clk = 0, rstn = 0, portReset = 0, latchStrobe = 0, ioSelect = 0;
    logic chipSelectLowN = 1, chipSelectHigh = 0, readStrobeN = 1, portWriteStrobeN = 1;
    logic portReadStrobeN = 1; // Idle high when unused
    logic busClock = 0, muxedBusLinesOe, waitOut, waitOe;
    logic [7:0] muxedBusLinesIn = 0, extA = 0, extB = 0;
    logic [7:0] muxedBusLinesOut, firstPortPinsIn, secondPortPinsIn;
    logic [2:0] upperRomAddress = 0;
    rwio_pins_s firstPortPins, secondPortPins;
    int n_errors = 0, n_tests = 0;
    always #50 clk = ~clk;
    rwio_slave DUT (
        .clk              (clk),
        .rstn             (rstn),
        .portReset        (portReset),
        .latchStrobe      (latchStrobe),
        .muxedBusLinesIn  (muxedBusLinesIn),
        .muxedBusLinesOut (muxedBusLinesOut),
        .muxedBusLinesOe  (muxedBusLinesOe),
        .upperRomAddress  (upperRomAddress),
        .ioSelect         (ioSelect),
        .chipSelectLowN   (chipSelectLowN),
        .chipSelectHigh   (chipSelectHigh),
        .readStrobeN      (readStrobeN),
        .portReadStrobeN  (portReadStrobeN),
        .portWriteStrobeN (portWriteStrobeN),
        .busClock         (busClock),
        .waitOut          (waitOut),
        .waitOe           (waitOe),
        .firstPortPinsIn  (firstPortPinsIn),
        .firstPortPins    (firstPortPins),
        .secondPortPinsIn (secondPortPinsIn),
        .secondPortPins   (secondPortPins)
    );
    rwio_pin_model pa (.drv(firstPortPins), .ext(extA), .level(firstPortPinsIn));
    rwio_pin_model pb (.drv(secondPortPins), .ext(extB), .level(secondPortPinsIn));
    task chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %0t saw %h expected %h", $time, s, e);
        end
    endtask
    task print_verdict;
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Address phase with wait handshake, enables inverted afterwards
    task latch(input logic [7:0] a, input logic [2:0] u, input logic io, input logic [1:0] cs);
        @(negedge clk);
        latchStrobe = 1; muxedBusLinesIn = a; upperRomAddress = u; ioSelect = io;
        {chipSelectLowN, chipSelectHigh} = cs;
        @(negedge clk);
        chk(waitOe, cs == 2'h1);
        chk(waitOut, 8'h00);
        latchStrobe = 0; busClock = 1; muxedBusLinesIn = ~a;
        {chipSelectLowN, chipSelectHigh} = ~cs;
        @(negedge clk);
        chk(waitOe, 8'h00);
        busClock = 0;
    endtask
    task rd(input logic rs, input logic prs, input logic en, input logic [7:0] e);
        @(negedge clk);
        readStrobeN = rs; portReadStrobeN = prs;
        @(negedge clk);
        chk(muxedBusLinesOe, en);
        if (en) chk(muxedBusLinesOut, e);
        readStrobeN = 1; portReadStrobeN = 1;
        @(negedge clk);
        chk(muxedBusLinesOe, 8'h00);
    endtask
    task wr(input logic [7:0] d);
        @(negedge clk);
        portWriteStrobeN = 0; muxedBusLinesIn = d;
        @(negedge clk);
        portWriteStrobeN = 1; muxedBusLinesIn = ~d;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        print_verdict;
    end
    // Main sequence
    initial begin
        logic [7:0] a;
        repeat (20) @(negedge clk);
        rstn = 1;
        chk(firstPortPins.oe | secondPortPins.oe, 8'h00);
        for (int i = 0; i < 8; i++) begin
            a = 8'(8'h11 * i);
            latch(a, 3'(i), 0, 2'h1);
            rd(0, 1, 1, a ^ {3'(i), 5'h00} ^ ROM_SEED);
        end
        latch(8'h02, 3'h7, 0, 2'h1); wr(8'hf0);
        latch(8'h00, 3'h5, 1, 2'h1); wr(8'ha5);
        latch(8'h01, 3'h0, 0, 2'h1); wr(8'h3c);
        extA = 8'h0f; extB = 8'h96;
        chk(firstPortPins.oe, 8'hf0);
        chk(firstPortPins.out, 8'ha5);
        chk(secondPortPins.out, 8'h3c);
        latch(8'h00, 3'h0, 0, 2'h1); rd(1, 0, 1, 8'haf);
        latch(8'h04, 3'h6, 1, 2'h1); rd(0, 1, 1, 8'haf);
        latch(8'h01, 3'h0, 1, 2'h1); rd(0, 1, 1, 8'h96);
        latch(8'h03, 3'h0, 1, 2'h1); wr(8'h0f);
        chk(secondPortPins.oe, 8'h0f);
        latch(8'h01, 3'h0, 1, 2'h1); rd(1, 0, 1, 8'h9c);
        latch(8'h00, 3'h0, 1, 2'h3); rd(0, 0, 0, 8'h00); wr(8'h00);
        latch(8'h00, 3'h0, 1, 2'h0); rd(0, 1, 0, 8'h00);
        chk(firstPortPins.out, 8'ha5);
        @(negedge clk) portReset = 1;
        @(negedge clk) portReset = 0;
        chk(firstPortPins.oe, 8'h00);
        chk(secondPortPins.oe, 8'h00);
        chk(firstPortPins.out, 8'ha5);
        print_verdict;
    end
endmodule // tb_top
